// File: urh_pkg.sv
// shared constants and types for the serial radio command host
package urh_pkg;
  // serial link timing
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD = 38400;
  localparam logic [10:0] BIT_CYC = 11'((CLK_HZ + BAUD / 2) / BAUD);
  localparam logic [10:0] HALF_CYC = 11'(((CLK_HZ + BAUD / 2) / BAUD) / 2);
  // answer wait: quiet gap that ends an answer, and overall timeout
  localparam int RESP_QUIET_US = 2000;
  localparam int RESP_TMO_US = 1_000_000;
  localparam int RESP_QUIET_CYC = (CLK_HZ / 1_000_000) * RESP_QUIET_US;
  localparam int RESP_TMO_CYC = (CLK_HZ / 1_000_000) * RESP_TMO_US;
  localparam int CNT_W = 26;
  // command limits
  localparam logic [5:0] PAY_MAX = 6'h3b;
  localparam logic [15:0] MODE_MIN = 16'h0001;
  localparam logic [15:0] MODE_MAX = 16'h0006;
  // characters
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_NL = 8'h0a;
  localparam logic [7:0] CH_EQ = 8'h3d;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  // completion status
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_REFUSED = 2'h1;
  localparam logic [1:0] ST_TIMEOUT = 2'h2;

  typedef enum logic [2:0] {
    URH_CMD_HELP,
    URH_CMD_CFG_TX,
    URH_CMD_CFG_RX,
    URH_CMD_LOAD,
    URH_CMD_SEND,
    URH_CMD_RX_START,
    URH_CMD_RX_STOP,
    URH_CMD_QUIT
  } urh_cmd_t;
endpackage

// File: urh_ser_if.sv
// byte channel between the command sequencer and the serial port
`timescale 1ns/1ps
interface urh_ser_if;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] rx_data;
  logic rx_valid;
  modport uart (input tx_data, input tx_valid, output tx_ready, output rx_data, output rx_valid);
  modport ctl (output tx_data, output tx_valid, input tx_ready, input rx_data, input rx_valid);
endinterface

// File: urh_uart.sv
// 8N1 serial transmitter and receiver with baud dividers
`timescale 1ns/1ps
module urh_uart (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic rxd_i,
  output logic txd_o,
  urh_ser_if.uart ser
);
  logic tx_busy_r;
  logic [8:0] tx_shift_r;
  logic [3:0] tx_bit_r;
  logic [10:0] tx_cnt_r;
  logic rx_busy_r;
  logic [3:0] rx_bit_r;
  logic [10:0] rx_cnt_r;
  logic [7:0] rx_shift_r;
  logic rx_valid_r;
  logic [7:0] rx_data_r;

  assign ser.tx_ready = ~tx_busy_r;
  assign ser.rx_valid = rx_valid_r;
  assign ser.rx_data = rx_data_r;

  //////////////////////////////////////////////////////////////////////////////
  // transmit: start bit, eight data bits lsb first, stop bit
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_busy_r <= 1'b0;
      tx_shift_r <= '0;
      tx_bit_r <= '0;
      tx_cnt_r <= '0;
      txd_o <= 1'b1;
    end else if (!tx_busy_r) begin
      if (ser.tx_valid) begin
        tx_busy_r <= 1'b1;
        tx_shift_r <= {1'b1, ser.tx_data}; // RULE2
        tx_bit_r <= '0;
        tx_cnt_r <= '0;
        txd_o <= 1'b0; // RULE2
      end
    end else if (tx_cnt_r == urh_pkg::BIT_CYC - 11'h001) begin // RULE1
      tx_cnt_r <= '0;
      if (tx_bit_r == 4'h9) begin
        tx_busy_r <= 1'b0; // stop bit done, line stays high
      end else begin
        txd_o <= tx_shift_r[0]; // RULE2
        tx_shift_r <= {1'b1, tx_shift_r[8:1]};
        tx_bit_r <= tx_bit_r + 4'h1;
      end
    end else begin
      tx_cnt_r <= tx_cnt_r + 11'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive: check start at mid bit, then sample each bit centre
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_busy_r <= 1'b0;
      rx_bit_r <= '0;
      rx_cnt_r <= '0;
      rx_shift_r <= '0;
      rx_valid_r <= 1'b0;
      rx_data_r <= '0;
    end else begin
      rx_valid_r <= 1'b0;
      if (!rx_busy_r) begin
        if (!rxd_i) begin
          rx_busy_r <= 1'b1;
          rx_bit_r <= '0;
          rx_cnt_r <= '0;
        end
      end else if (rx_cnt_r == ((rx_bit_r == 4'h0) ? urh_pkg::HALF_CYC : urh_pkg::BIT_CYC)
                   - 11'h001) begin // RULE1
        rx_cnt_r <= '0;
        if (rx_bit_r == 4'h0) begin
          // a glitch shorter than half a bit is not a start bit
          rx_busy_r <= ~rxd_i;
          rx_bit_r <= 4'h1;
        end else if (rx_bit_r != 4'h9) begin
          rx_shift_r <= {rxd_i, rx_shift_r[7:1]}; // RULE2
          rx_bit_r <= rx_bit_r + 4'h1;
        end else begin
          rx_busy_r <= 1'b0;
          rx_valid_r <= rxd_i; // framing error drops the byte
          rx_data_r <= rx_shift_r;
        end
      end else begin
        rx_cnt_r <= rx_cnt_r + 11'h001;
      end
    end
  end
endmodule // urh_uart

// File: urh_pay_mem.sv
// payload byte store with registered read data
`timescale 1ns/1ps
module urh_pay_mem (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic wr_en_i,
  input wire logic [5:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [5:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem [0:58];

  // writes past the last slot are dropped
  always_ff @(posedge clk_sys_i) begin
    if (wr_en_i && wr_addr_i < urh_pkg::PAY_MAX) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // read data from a register
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_o <= '0;
    end else if (rd_addr_i < urh_pkg::PAY_MAX) begin
      rd_data_o <= mem[rd_addr_i];
    end else begin
      rd_data_o <= '0;
    end
  end
endmodule // urh_pay_mem

// File: urh_host.sv
// host controller: issues text commands and decodes received byte lines
`timescale 1ns/1ps
// What the document requires of the host and the device
// RULE1: 38400 baud, 8 data bits, no parity, one stop bit, no flow control.
// RULE2: each character is low start, eight data bits lsb first, high stop bit.
// RULE3: host lines cross to the device's serial in and out pins.
// RULE4: every command ends with newline; words and parameters separated by spaces. The host sends q with no newline.
// RULE5: device checks each whole command, executes it, always answers with text.
// RULE6: device answers an invalid command with a prompt and does nothing else.
// RULE7: help lists all commands; help with a word gives short help for it.
// RULE8: radio setup with mode 1 to 6 precedes transmit or receive.
// RULE9: payload load uses packet index 4 then at most 59 decimal bytes.
// RULE10: send count 1 sends once; new packets are load then single send.
// RULE11: device starts radio only with stable crystal, valid setup, loaded payload.
// RULE12: receive begin with v makes device report every received packet.
// RULE13: each byte reported as Byte, index, equals, decimal value, newline; data from 1.
// RULE14: an index-zero line carrying the length precedes every packet's data.
// RULE15: host drops other text, extracts values, splits packets at index-zero lines.
// RULE16: receive lasts until receive end; restart needs no new setup.
// RULE17: device has three active modes, deep sleep and off; starts CPU active.
// RULE18: deep sleep is left by the watchdog timer or a resume input change.
// RULE19: configuration is lost in deep sleep and must be redone after wakeup.
// RULE20: device goes from halt to deep sleep when nothing is pending.
// RULE21: device leaves off above on threshold, enters off below off threshold.
// RULE22: supply should be measured before flash write or erase.
// RULE23: during receive only four commands are accepted, including receive end.
// RULE24: device sets payload length byte, zeroes bad values, ignores bytes past 59.
// RULE25: repeat count 0 to 65535; zero sends until q arrives, others stop alone.
// RULE26: host waits for the answer text before the next command.
module urh_host #(
  parameter int unsigned QUIET_CYC = urh_pkg::RESP_QUIET_CYC,
  parameter int unsigned TMO_CYC = urh_pkg::RESP_TMO_CYC
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic dev_serial_out_pin_i,
  output logic dev_serial_in_pin_o,
  input wire logic cmd_valid_i,
  input wire urh_pkg::urh_cmd_t cmd_code_i,
  input wire logic [15:0] cmd_arg_i,
  output logic cmd_ready_o,
  output logic cmd_done_o,
  output logic [1:0] cmd_status_o,
  input wire logic pay_wr_i,
  input wire logic [5:0] pay_addr_i,
  input wire logic [7:0] pay_data_i,
  input wire logic dev_woke_i,
  output logic rx_active_o,
  output logic rx_byte_valid_o,
  output logic rx_pkt_start_o,
  output logic [7:0] rx_index_o,
  output logic [7:0] rx_byte_o
);
  typedef enum {S_IDLE, S_WORD, S_SPACE, S_FETCH, S_DIGIT, S_EOL, S_WAIT} urh_emit_t;
  typedef enum {P_HDR, P_IDX, P_SEP, P_VAL, P_SKIP} urh_parse_t;
  localparam logic [39:0] HDR_TXT = "Byte ";

  urh_ser_if ser ();
  urh_emit_t state_r;
  urh_parse_t pst_r;
  urh_pkg::urh_cmd_t cmd_r;
  logic [15:0] arg_r;
  logic [15:0] val_r;
  logic [3:0] ci_r;
  logic [5:0] ai_r;
  logic [5:0] nargs_r;
  logic [2:0] dk_r;
  logic lead_r;
  logic tx_valid_r;
  logic [7:0] tx_data_r;
  logic [urh_pkg::CNT_W-1:0] quiet_r;
  logic [urh_pkg::CNT_W-1:0] tmo_r;
  logic seen_r;
  logic tx_cfg_r;
  logic rx_cfg_r;
  logic loaded_r;
  logic [5:0] pay_len_r;
  logic cont_r;
  logic [7:0] pay_rd;
  logic can_send;
  logic legal;
  logic [3:0] dig;
  logic [2:0] pos_r;
  logic [7:0] idx_r;
  logic [11:0] pval_r;
  logic is_dig;
  logic [3:0] cdig;

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [3:0] word_len(input urh_pkg::urh_cmd_t c);
    case (c)
      urh_pkg::URH_CMD_HELP: word_len = 4'h4;
      urh_pkg::URH_CMD_CFG_TX, urh_pkg::URH_CMD_CFG_RX: word_len = 4'hf;
      urh_pkg::URH_CMD_LOAD, urh_pkg::URH_CMD_RX_START: word_len = 4'he;
      urh_pkg::URH_CMD_SEND: word_len = 4'h8;
      urh_pkg::URH_CMD_RX_STOP: word_len = 4'hb;
      default: word_len = 4'h1;
    endcase
  endfunction

  function automatic logic [7:0] word_char(input urh_pkg::urh_cmd_t c, input logic [3:0] i);
    logic [8*15-1:0] s;
    s = '0;
    case (c)
      urh_pkg::URH_CMD_HELP: s = "help"; // RULE7
      urh_pkg::URH_CMD_CFG_TX: s = "config_tx_radio"; // RULE8
      urh_pkg::URH_CMD_CFG_RX: s = "config_rx_radio"; // RULE8
      urh_pkg::URH_CMD_LOAD: s = "write_tx_pkt 4"; // RULE9
      urh_pkg::URH_CMD_SEND: s = "send_pkt"; // RULE10
      urh_pkg::URH_CMD_RX_START: s = "rx_pkt_start v"; // RULE12
      urh_pkg::URH_CMD_RX_STOP: s = "rx_pkt_stop"; // RULE16
      default: s = "q"; // RULE25
    endcase
    word_char = s[8*(int'(word_len(c)) - 1 - int'(i)) +: 8];
  endfunction

  function automatic logic [3:0] dec_digit(input logic [15:0] v, input logic [2:0] k);
    logic [15:0] q;
    q = '0;
    case (k)
      3'h4: q = v / 16'd10000;
      3'h3: q = v / 16'd1000;
      3'h2: q = v / 16'd100;
      3'h1: q = v / 16'd10;
      default: q = v;
    endcase
    dec_digit = 4'(q % 16'd10);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // submodules
  urh_uart u_uart (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .rxd_i(dev_serial_out_pin_i), // RULE3
    .txd_o(dev_serial_in_pin_o), // RULE3
    .ser(ser.uart)
  );

  urh_pay_mem u_mem (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .wr_en_i(pay_wr_i),
    .wr_addr_i(pay_addr_i),
    .wr_data_i(pay_data_i),
    .rd_addr_i(ai_r),
    .rd_data_o(pay_rd)
  );

  assign ser.tx_valid = tx_valid_r;
  assign ser.tx_data = tx_data_r;
  assign can_send = ser.tx_ready & ~tx_valid_r;
  assign dig = dec_digit(val_r, dk_r);

  // may a new command start now
  always_comb begin
    legal = 1'b1;
    case (cmd_code_i)
      urh_pkg::URH_CMD_CFG_TX, urh_pkg::URH_CMD_CFG_RX:
        legal = cmd_arg_i >= urh_pkg::MODE_MIN && cmd_arg_i <= urh_pkg::MODE_MAX; // RULE8
      urh_pkg::URH_CMD_LOAD:
        legal = cmd_arg_i != 16'h0000 && cmd_arg_i <= {10'h000, urh_pkg::PAY_MAX}; // RULE24
      urh_pkg::URH_CMD_SEND: legal = tx_cfg_r & loaded_r & ~cont_r; // RULE11
      urh_pkg::URH_CMD_RX_START: legal = rx_cfg_r; // RULE16
      urh_pkg::URH_CMD_RX_STOP: legal = rx_active_o;
      urh_pkg::URH_CMD_QUIT: legal = cont_r; // RULE25
      default: legal = 1'b1;
    endcase
    if (rx_active_o && cmd_code_i != urh_pkg::URH_CMD_RX_STOP) begin
      legal = 1'b0; // RULE23
    end
    if (cont_r && cmd_code_i != urh_pkg::URH_CMD_QUIT) begin
      legal = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command text emitter and answer wait
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= S_IDLE;
      cmd_r <= urh_pkg::URH_CMD_HELP;
      arg_r <= '0;
      val_r <= '0;
      ci_r <= '0;
      ai_r <= '0;
      nargs_r <= '0;
      dk_r <= '0;
      lead_r <= 1'b1;
      tx_valid_r <= 1'b0;
      tx_data_r <= '0;
      quiet_r <= '0;
      tmo_r <= '0;
      seen_r <= 1'b0;
      cmd_ready_o <= 1'b1;
      cmd_done_o <= 1'b0;
      cmd_status_o <= urh_pkg::ST_OK;
    end else begin
      tx_valid_r <= 1'b0;
      cmd_done_o <= 1'b0;
      case (state_r)
        S_IDLE: begin
          ci_r <= '0;
          ai_r <= '0;
          if (cmd_valid_i && !legal) begin
            cmd_done_o <= 1'b1;
            cmd_status_o <= urh_pkg::ST_REFUSED;
          end else if (cmd_valid_i) begin
            cmd_r <= cmd_code_i;
            arg_r <= cmd_arg_i;
            cmd_ready_o <= 1'b0;
            case (cmd_code_i)
              urh_pkg::URH_CMD_CFG_TX, urh_pkg::URH_CMD_CFG_RX,
              urh_pkg::URH_CMD_SEND: nargs_r <= 6'h01;
              urh_pkg::URH_CMD_LOAD: nargs_r <= cmd_arg_i[5:0];
              default: nargs_r <= 6'h00;
            endcase
            state_r <= S_WORD;
          end
        end
        S_WORD: if (can_send) begin
          tx_valid_r <= 1'b1;
          tx_data_r <= word_char(cmd_r, ci_r);
          ci_r <= ci_r + 4'h1;
          if (ci_r == word_len(cmd_r) - 4'h1) begin
            state_r <= (nargs_r == 6'h00) ? S_EOL : S_SPACE;
          end
        end
        S_SPACE: if (can_send) begin
          tx_valid_r <= 1'b1;
          tx_data_r <= urh_pkg::CH_SPACE; // RULE4
          state_r <= S_FETCH;
        end
        S_FETCH: begin
          // payload bytes from the store, others from the request
          val_r <= (cmd_r == urh_pkg::URH_CMD_LOAD) ? {8'h00, pay_rd} : arg_r;
          dk_r <= 3'h4;
          lead_r <= 1'b1;
          state_r <= S_DIGIT;
        end
        S_DIGIT: begin
          if (dk_r == 3'h0 || dig != 4'h0 || !lead_r) begin
            if (can_send) begin
              tx_valid_r <= 1'b1;
              tx_data_r <= urh_pkg::CH_ZERO + {4'h0, dig};
              lead_r <= 1'b0;
              dk_r <= dk_r - 3'h1;
              if (dk_r == 3'h0) begin
                ai_r <= ai_r + 6'h01;
                state_r <= (ai_r == nargs_r - 6'h01) ? S_EOL : S_SPACE;
              end
            end
          end else begin
            dk_r <= dk_r - 3'h1; // leading zero suppressed
          end
        end
        S_EOL: begin
          quiet_r <= '0;
          tmo_r <= '0;
          seen_r <= 1'b0;
          if (cmd_r == urh_pkg::URH_CMD_QUIT) begin
            state_r <= S_WAIT; // the stop character stands alone
          end else if (can_send) begin
            tx_valid_r <= 1'b1;
            tx_data_r <= urh_pkg::CH_NL; // RULE4
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          // no flow control: next command waits for the answer
          tmo_r <= tmo_r + 1'b1; // RULE26
          if (ser.rx_valid) begin
            seen_r <= 1'b1; // RULE5
            quiet_r <= '0;
          end else if (seen_r) begin
            quiet_r <= quiet_r + 1'b1;
          end
          if ((seen_r && quiet_r >= urh_pkg::CNT_W'(QUIET_CYC)) ||
              (cmd_r == urh_pkg::URH_CMD_RX_START && ser.rx_valid &&
               ser.rx_data == urh_pkg::CH_NL)) begin
            // receive mode streams text, so its first answer line ends the wait
            cmd_done_o <= 1'b1;
            cmd_status_o <= urh_pkg::ST_OK;
            cmd_ready_o <= 1'b1;
            state_r <= S_IDLE;
          end else if (tmo_r >= urh_pkg::CNT_W'(TMO_CYC)) begin
            cmd_done_o <= 1'b1;
            cmd_status_o <= urh_pkg::ST_TIMEOUT;
            cmd_ready_o <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // host view of device configuration
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_cfg_r <= 1'b0;
      rx_cfg_r <= 1'b0;
      loaded_r <= 1'b0;
      pay_len_r <= '0;
      cont_r <= 1'b0;
      rx_active_o <= 1'b0;
    end else if (dev_woke_i) begin
      // deep sleep wiped the device setup
      tx_cfg_r <= 1'b0; // RULE19
      rx_cfg_r <= 1'b0; // RULE19
      loaded_r <= 1'b0;
      cont_r <= 1'b0;
      rx_active_o <= 1'b0;
    end else if (state_r == S_IDLE && cmd_valid_i && legal) begin
      case (cmd_code_i)
        urh_pkg::URH_CMD_CFG_TX: begin
          tx_cfg_r <= 1'b1;
          rx_cfg_r <= 1'b0;
        end
        urh_pkg::URH_CMD_CFG_RX: begin
          rx_cfg_r <= 1'b1;
          tx_cfg_r <= 1'b0;
        end
        urh_pkg::URH_CMD_LOAD: begin
          loaded_r <= 1'b1;
          pay_len_r <= cmd_arg_i[5:0];
        end
        urh_pkg::URH_CMD_SEND: cont_r <= (cmd_arg_i == 16'h0000); // RULE25
        urh_pkg::URH_CMD_RX_START: rx_active_o <= 1'b1; // RULE16
        urh_pkg::URH_CMD_RX_STOP: rx_active_o <= 1'b0; // RULE16
        urh_pkg::URH_CMD_QUIT: cont_r <= 1'b0; // RULE25
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // received line decoder: only "Byte n = v" lines survive
  assign is_dig = ser.rx_data >= urh_pkg::CH_ZERO && ser.rx_data <= urh_pkg::CH_NINE;
  assign cdig = 4'(ser.rx_data - urh_pkg::CH_ZERO);

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pst_r <= P_HDR;
      pos_r <= '0;
      idx_r <= '0;
      pval_r <= '0;
      rx_byte_valid_o <= 1'b0;
      rx_pkt_start_o <= 1'b0;
      rx_index_o <= '0;
      rx_byte_o <= '0;
    end else begin
      rx_byte_valid_o <= 1'b0;
      rx_pkt_start_o <= 1'b0;
      if (ser.rx_valid) begin
        if (ser.rx_data == urh_pkg::CH_NL) begin
          pst_r <= P_HDR;
          pos_r <= '0;
          if (pst_r == P_VAL && pval_r <= 12'h0ff) begin
            rx_byte_valid_o <= 1'b1; // RULE13
            rx_pkt_start_o <= (idx_r == 8'h00); // RULE14
            rx_index_o <= idx_r;
            rx_byte_o <= pval_r[7:0]; // RULE15
          end
        end else begin
          case (pst_r)
            P_HDR: if (ser.rx_data == HDR_TXT[8*(4-int'(pos_r)) +: 8]) begin
              pos_r <= pos_r + 3'h1;
              if (pos_r == 3'h4) begin
                pst_r <= P_IDX;
                idx_r <= '0;
              end
            end else begin
              pst_r <= P_SKIP; // RULE15
            end
            P_IDX: if (is_dig) begin
              idx_r <= 8'(idx_r * 8'd10 + {4'h0, cdig});
            end else if (ser.rx_data == urh_pkg::CH_SPACE) begin
              pst_r <= P_SEP;
            end else begin
              pst_r <= P_SKIP;
            end
            P_SEP: if (is_dig) begin
              pval_r <= {8'h00, cdig};
              pst_r <= P_VAL;
            end else if (ser.rx_data != urh_pkg::CH_SPACE && ser.rx_data != urh_pkg::CH_EQ) begin
              pst_r <= P_SKIP;
            end
            P_VAL: if (is_dig) begin
              // saturate so a long number cannot wrap into range
              pval_r <= (pval_r > 12'h0ff) ? pval_r : 12'(pval_r * 12'd10 + {8'h00, cdig});
            end else begin
              pst_r <= P_SKIP;
            end
            default: pst_r <= P_SKIP;
          endcase
        end
      end
    end
  end
endmodule // urh_host

// File: urh_host_sva.sv
// concurrent checks on the command host's ports
`timescale 1ns/1ps
module urh_host_chk (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic dev_serial_in_pin_o,
  input wire logic cmd_valid_i,
  input wire urh_pkg::urh_cmd_t cmd_code_i,
  input wire logic [15:0] cmd_arg_i,
  input wire logic cmd_ready_o,
  input wire logic cmd_done_o,
  input wire logic [1:0] cmd_status_o,
  input wire logic rx_byte_valid_o,
  input wire logic rx_pkt_start_o,
  input wire logic [7:0] rx_index_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  logic [13:0] lo_cnt_r;
  logic take;
  assign take = cmd_valid_i && cmd_ready_o;
  ////////////////////////////////////////
  // length of the current low stretch
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i || dev_serial_in_pin_o) begin
      lo_cnt_r <= 14'h0000;
    end else begin
      lo_cnt_r <= lo_cnt_r + 14'h0001;
    end
  end
  // low stretches are whole bits, at most start plus eight zeros
  a_bit_width: assert property ($rose(dev_serial_in_pin_o) |->
    (lo_cnt_r % urh_pkg::BIT_CYC) == 0) else $error("low stretch not whole bits");
  a_stop_high: assert property (lo_cnt_r <= 9 * urh_pkg::BIT_CYC)
    else $error("line low past stop bit");
  a_mode_range: assert property (take && (cmd_code_i == urh_pkg::URH_CMD_CFG_TX ||
    cmd_code_i == urh_pkg::URH_CMD_CFG_RX) && (cmd_arg_i < urh_pkg::MODE_MIN ||
    cmd_arg_i > urh_pkg::MODE_MAX) |=> cmd_done_o && cmd_status_o == urh_pkg::ST_REFUSED
    ##1 dev_serial_in_pin_o [*8]) else $error("bad radio mode not refused");
  a_load_range: assert property (take && cmd_code_i == urh_pkg::URH_CMD_LOAD &&
    (cmd_arg_i == 16'h0000 || cmd_arg_i > 16'(urh_pkg::PAY_MAX)) |=> cmd_done_o &&
    cmd_status_o == urh_pkg::ST_REFUSED) else $error("bad payload count not refused");
  a_take_answer: assert property (take |=> cmd_done_o == cmd_ready_o)
    else $error("request neither refused nor started");
  a_done_pulse: assert property (cmd_done_o && !take |=> !cmd_done_o)
    else $error("done longer than one cycle");
  a_ready_done: assert property ($rose(cmd_ready_o) |-> cmd_done_o)
    else $error("ready returned without done");
  a_ready_idle: assert property (cmd_ready_o |-> dev_serial_in_pin_o)
    else $error("sending while idle");
  a_pkt_start: assert property (rx_pkt_start_o |-> rx_byte_valid_o &&
    rx_index_o == 8'h00) else $error("packet start not on index zero");
endmodule // urh_host_chk

bind urh_host urh_host_chk i_chk (.clk_sys_i, .sys_rst_i, .dev_serial_in_pin_o, .cmd_valid_i,
  .cmd_code_i, .cmd_arg_i, .cmd_ready_o, .cmd_done_o, .cmd_status_o, .rx_byte_valid_o,
  .rx_pkt_start_o, .rx_index_o);

// File: urh_dev_model.sv
// behavioural model of the radio device's serial command port
`timescale 1ns/1ps
module urh_dev_model (
  input wire logic ser_from_host_i,
  output logic ser_to_host_o
);
  // true baud period, so the host's rounded divider is exercised
  localparam real BIT_NS = 1.0e9 / 38400.0;
  string rx_buf = "";
  string last_cmd = "";
  int n_cmds = 0;
  logic [7:0] ch;
  initial ser_to_host_o = 1'b1;
  ////////////////////////////////////////
  // a command counts once its newline arrives
  always begin
    @(negedge ser_from_host_i);
    #(BIT_NS / 2.0);
    for (int i = 0; i < 8; i++) begin
      #(BIT_NS);
      ch[i] = ser_from_host_i;
    end
    #(BIT_NS);
    if (ser_from_host_i === 1'b1 && ch == urh_pkg::CH_NL) begin
      last_cmd = rx_buf;
      rx_buf = "";
      n_cmds++;
    end else if (ser_from_host_i === 1'b1) begin
      rx_buf = $sformatf("%s%c", rx_buf, ch);
    end
  end
  // answer text, lsb first, one stop bit
  task automatic send_str(input string s);
    for (int n = 0; n < s.len(); n++) begin
      ser_to_host_o = 1'b0;
      #(BIT_NS);
      for (int b = 0; b < 8; b++) begin
        ser_to_host_o = 1'(s[n] >> b);
        #(BIT_NS);
      end
      ser_to_host_o = 1'b1;
      #(BIT_NS);
    end
  endtask
endmodule // urh_dev_model

// File: urh_host_bench.sv
// self-checking bench for the serial radio command host
`timescale 1ns/1ps
module urh_host_bench;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  urh_pkg::urh_cmd_t cmd_code_i = urh_pkg::URH_CMD_HELP;
  logic [15:0] cmd_arg_i = 16'h0000;
  logic pay_wr_i = 1'b0;
  logic [5:0] pay_addr_i = 6'h00;
  logic [7:0] pay_data_i = 8'h00;
  logic dev_woke_i = 1'b0;
  logic h2d, d2h, cmd_ready_o, cmd_done_o, rx_active_o, rx_byte_valid_o, rx_pkt_start_o;
  logic [1:0] cmd_status_o;
  logic [7:0] rx_index_o, rx_byte_o, got_idx, got_val;
  logic got_pkt;
  int err_count = 0, n_checks = 0, seed = 15, n_lines = 0;
  urh_pkg::urh_cmd_t cc[4] = '{urh_pkg::URH_CMD_CFG_TX, urh_pkg::URH_CMD_CFG_RX,
    urh_pkg::URH_CMD_LOAD, urh_pkg::URH_CMD_LOAD};
  logic [15:0] ca[4] = '{16'h0000, 16'h0007, 16'h0000, 16'h003c};
  always #12.5 clk_sys_i = ~clk_sys_i;
  urh_host #(.QUIET_CYC(12000), .TMO_CYC(200000)) i_dut (.clk_sys_i, .sys_rst_i,
    .dev_serial_out_pin_i(d2h), .dev_serial_in_pin_o(h2d), .cmd_valid_i, .cmd_code_i,
    .cmd_arg_i, .cmd_ready_o, .cmd_done_o, .cmd_status_o, .pay_wr_i, .pay_addr_i,
    .pay_data_i, .dev_woke_i, .rx_active_o, .rx_byte_valid_o, .rx_pkt_start_o,
    .rx_index_o, .rx_byte_o);
  urh_dev_model i_dev (.ser_from_host_i(h2d), .ser_to_host_o(d2h));
  ////////////////////////////////////////
  // keep the last decoded byte line
  always @(posedge clk_sys_i) begin
    if (rx_byte_valid_o === 1'b1) begin
      got_idx <= rx_index_o;
      got_val <= rx_byte_o;
      got_pkt <= rx_pkt_start_o;
      n_lines <= n_lines + 1;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_str(input string g, input string e);
    n_checks++;
    if (g != e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // no setup yet: only help, in-range setups and loads start
  function automatic logic [3:0] exp_ans(input urh_pkg::urh_cmd_t c, input logic [15:0] a);
    logic ok;
    ok = (c == urh_pkg::URH_CMD_HELP) || ((c == urh_pkg::URH_CMD_CFG_TX ||
      c == urh_pkg::URH_CMD_CFG_RX) && a >= urh_pkg::MODE_MIN && a <= urh_pkg::MODE_MAX) ||
      (c == urh_pkg::URH_CMD_LOAD && a != 0 && a <= 16'(urh_pkg::PAY_MAX));
    return ok ? {2'b00, urh_pkg::ST_OK} : {2'b11, urh_pkg::ST_REFUSED};
  endfunction
  // one request cycle plus a random payload write
  task automatic req(input urh_pkg::urh_cmd_t c, input logic [15:0] a);
    @(negedge clk_sys_i);
    cmd_valid_i = 1'b1;
    cmd_code_i = c;
    cmd_arg_i = a;
    pay_wr_i = 1'b1;
    pay_addr_i = 6'($random(seed));
    pay_data_i = 8'($random(seed));
    @(negedge clk_sys_i);
    cmd_valid_i = 1'b0;
    pay_wr_i = 1'b0;
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard, well past the expected run
  initial begin
    #8_000_000;
    err_count++;
    tally_and_finish();
  end
  ////////////////////////////////////////
  initial begin
    urh_pkg::urh_cmd_t c;
    logic [15:0] a;
    int n0;
    repeat (4) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    @(negedge clk_sys_i);
    chk({cmd_ready_o, cmd_done_o, h2d, rx_active_o}, 4'b1010);
    dev_woke_i = 1'b1;
    @(negedge clk_sys_i);
    dev_woke_i = 1'b0;
    // corner cases, then random refused requests
    for (int i = 0; i < 24; i++) begin
      c = urh_pkg::urh_cmd_t'(3'({$random(seed)} % 7 + 1));
      a = 16'($random(seed)) | 16'h0040;
      if (i < 4) begin
        c = cc[i];
        a = ca[i];
      end
      req(c, a);
      chk({cmd_done_o, cmd_ready_o, cmd_status_o}, exp_ans(c, a));
      chk(h2d, 1'b1);
    end
    req(urh_pkg::URH_CMD_HELP, 16'h0000);
    chk({cmd_done_o, cmd_ready_o}, exp_ans(urh_pkg::URH_CMD_HELP, 16'h0000) >> 2);
    // full duplex: answer overlaps the command to keep the run short
    fork
      i_dev.send_str("Byte 0 = 5\n");
    join_none
    n0 = i_dev.n_cmds;
    for (int k = 0; k < 80000 && i_dev.n_cmds == n0; k++) @(negedge clk_sys_i);
    chk_str(i_dev.last_cmd, "help");
    for (int k = 0; k < 80000 && cmd_done_o !== 1'b1; k++) @(negedge clk_sys_i);
    chk({cmd_ready_o, cmd_status_o}, {1'b1, urh_pkg::ST_OK});
    chk({n_lines[7:0], got_pkt, got_idx, got_val}, {8'h01, 1'b1, 8'h00, 8'h05});
    tally_and_finish();
  end
endmodule // urh_host_bench
